//--- inc/core_state_pkg.sv
// constants for the core state block: flags, register file, stack pointer
// assumes a single core clock and a data/io access port from the core
// Function
// RULE1: global interrupt enable lives in flag bit 7 and gates interrupts.
// RULE2: with global enable clear, no interrupt is taken whatever source enables say.
// RULE3: taking an interrupt clears global enable; return-from-irq sets it.
// RULE4: set-interrupt op sets global enable, clear-interrupt op clears it.
// RULE5: flag bit 6 is a one-bit store for bit store and bit load ops.
// RULE6: flag bit 5 holds low nibble carry from arithmetic that defines it.
// RULE7: flag bit 4 always equals negative xor overflow.
// RULE8: flag bit 3 holds two's complement overflow.
// RULE9: flag bit 2 set on negative result, else cleared.
// RULE10: flag bit 1 set on zero result, else cleared.
// RULE11: flag bit 0 holds carry of the operation.
// RULE12: register file offers 8r/8w, 2x8r/8w, 2x8r/16w and 16r/16w access.
// RULE13: 32 working registers appear at data addresses 0x00 to 0x1F.
// RULE14: registers 26..31 form three pointers, low byte at even address.
// RULE15: pointers support displacement, post increment and pre decrement.
// RULE16: stack grows down; one byte push decrements, pop increments by 1.
// RULE17: calls and interrupt entry decrement stack pointer by 2.
// RULE18: subroutine and interrupt returns increment stack pointer by 2.
// RULE19: stack pointer resets to last SRAM address.
// RULE20: stack pointer is two io registers, high 0x3E, low 0x3D.
// RULE21: core runs straight off system clock, no division.
// RULE22: read two operands, compute, write back in one cycle. Operand reads are registered and arrive a cycle after the index.
package core_state_pkg;
    localparam int unsigned FLAG_IRQ_EN = 7;
    localparam int unsigned FLAG_BIT_STORE = 6;
    localparam int unsigned FLAG_HALF = 5;
    localparam int unsigned FLAG_SIGN = 4;
    localparam int unsigned FLAG_OVF = 3;
    localparam int unsigned FLAG_NEG = 2;
    localparam int unsigned FLAG_ZERO = 1;
    localparam int unsigned FLAG_CARRY = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam int unsigned NUM_REGS = 32;
    localparam logic [15:0] REGS_FIRST_ADDR = 16'h0000;
    localparam logic [15:0] REGS_LAST_ADDR = 16'h001F;
    localparam logic [4:0] PTR_FIRST_LOW = 5'h1A;
    localparam logic [4:0] PTR_SECOND_LOW = 5'h1C;
    localparam logic [4:0] PTR_THIRD_LOW = 5'h1E;
    localparam logic [5:0] IO_SP_LOW = 6'h3D;
    localparam logic [5:0] IO_SP_HIGH = 6'h3E;
    localparam logic [5:0] IO_FLAGS = 6'h3F;
    localparam logic [15:0] LAST_SRAM_ADDRESS = 16'h08FF;
    localparam int unsigned SP_BITS = 12;
    typedef enum logic [2:0] {
        SP_HOLD, SP_PUSH1, SP_POP1, SP_PUSH2, SP_POP2
    } sp_op_t;
    typedef enum logic [1:0] {
        PTR_DISP, PTR_POST_INC, PTR_PRE_DEC
    } ptr_mode_t;
    typedef enum logic [1:0] {
        IE_KEEP, IE_SET, IE_CLEAR
    } ie_op_t;
endpackage : core_state_pkg

//--- hdl/stack_pointer_unit.sv
// stack pointer with io byte access and push/pop stepping
// assumes io writes and stack ops are never issued in the same cycle
`timescale 1ns/10ps
`default_nettype none
module stack_pointer_unit #(
    parameter int unsigned SP_WIDTH = core_state_pkg::SP_BITS,
    parameter logic [15:0] RESET_VALUE = core_state_pkg::LAST_SRAM_ADDRESS
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire core_state_pkg::sp_op_t op_i,
    input wire logic wr_low_i,
    input wire logic wr_high_i,
    input wire logic [7:0] wdata_i,
    output logic [15:0] sp_o
);
    logic [SP_WIDTH-1:0] sp;
    logic [SP_WIDTH-1:0] next_sp;
    logic [15:0] sp_wide;
    logic [15:0] step_sp;
    assign sp_wide = {{(16 - SP_WIDTH){1'b0}}, sp};
    assign step_sp = (op_i == core_state_pkg::SP_PUSH1) ? sp_wide - 16'h0001 : // RULE16
                     (op_i == core_state_pkg::SP_POP1) ? sp_wide + 16'h0001 : // RULE16
                     (op_i == core_state_pkg::SP_PUSH2) ? sp_wide - 16'h0002 : // RULE17
                     (op_i == core_state_pkg::SP_POP2) ? sp_wide + 16'h0002 : // RULE18
                     sp_wide;
    always_comb begin
        next_sp = step_sp[SP_WIDTH-1:0];
        if (wr_low_i) begin
            next_sp[7:0] = wdata_i; // RULE20
        end
        if (wr_high_i) begin
            next_sp[SP_WIDTH-1:8] = wdata_i[SP_WIDTH-9:0]; // RULE20
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            sp <= RESET_VALUE[SP_WIDTH-1:0]; // RULE19
        end else begin
            sp <= next_sp;
        end
    end
    assign sp_o = sp_wide;
endmodule : stack_pointer_unit
`default_nettype wire

//--- hdl/flags_unit.sv
// core flag register: interrupt enable, bit store, alu flags
// assumes alu supplies raw flag values and an update mask each cycle
`timescale 1ns/10ps
`default_nettype none
module flags_unit (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire core_state_pkg::ie_op_t ie_op_i,
    input wire logic irq_taken_i,
    input wire logic bit_store_op_i,
    input wire logic bit_store_val_i,
    input wire logic [5:0] alu_flags_i,
    input wire logic [5:0] alu_mask_i,
    input wire logic io_wr_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] flags_o
);
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic [5:0] merged;
    // bits 5 and 3..0 follow the alu where its mask says so; bit 4 is rebuilt from bits 2 and 3
    assign merged = (flags[5:0] & ~alu_mask_i) | (alu_flags_i & alu_mask_i); // RULE6 RULE8 RULE9 RULE10 RULE11
    always_comb begin
        next_flags = io_wr_i ? io_wdata_i : {flags[7:6], merged};
        if (bit_store_op_i) begin
            next_flags[core_state_pkg::FLAG_BIT_STORE] = bit_store_val_i; // RULE5
        end
        case (ie_op_i)
            core_state_pkg::IE_SET: next_flags[core_state_pkg::FLAG_IRQ_EN] = 1'b1; // RULE3 RULE4
            core_state_pkg::IE_CLEAR: next_flags[core_state_pkg::FLAG_IRQ_EN] = 1'b0; // RULE4
            default: ;
        endcase
        if (irq_taken_i) begin
            next_flags[core_state_pkg::FLAG_IRQ_EN] = 1'b0; // RULE3
        end
        next_flags[core_state_pkg::FLAG_SIGN] = next_flags[core_state_pkg::FLAG_NEG]
            ^ next_flags[core_state_pkg::FLAG_OVF]; // RULE7
    end
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            flags <= core_state_pkg::FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end
    assign flags_o = flags;
endmodule : flags_unit
`default_nettype wire

//--- hdl/cpu_flags_regfile_stack.sv
// core state: flags, 32-entry register file, pointer pairs, stack pointer
// assumes decoder drives one-cycle controls; single clock straight from source
`timescale 1ns/10ps
`default_nettype none
module cpu_flags_regfile_stack #(
    parameter int unsigned SP_WIDTH = core_state_pkg::SP_BITS,
    parameter logic [15:0] SRAM_LAST = core_state_pkg::LAST_SRAM_ADDRESS
) (
    input wire logic clk_sys_i, // RULE21
    input wire logic sys_rst_i,
    // operand reads
    input wire logic [4:0] rd_a_idx_i,
    input wire logic [4:0] rd_b_idx_i,
    input wire logic rd_wide_i,
    output logic [15:0] rd_a_data_o,
    output logic [7:0] rd_b_data_o,
    // result write
    input wire logic wr_en_i,
    input wire logic wr_wide_i,
    input wire logic [4:0] wr_idx_i,
    input wire logic [15:0] wr_data_i,
    // flags from alu
    input wire logic [5:0] alu_flags_i,
    input wire logic [5:0] alu_mask_i,
    // bit copy
    input wire logic bit_store_op_i,
    input wire logic bit_load_op_i,
    input wire logic [4:0] bit_reg_i,
    input wire logic [2:0] bit_sel_i,
    // interrupt control
    input wire logic irq_request_i,
    input wire logic irq_taken_i,
    input wire core_state_pkg::ie_op_t ie_op_i,
    output logic irq_accept_o,
    // stack
    input wire core_state_pkg::sp_op_t sp_op_i,
    // pointer addressing
    input wire logic ptr_en_i,
    input wire logic [1:0] ptr_sel_i,
    input wire core_state_pkg::ptr_mode_t ptr_mode_i,
    input wire logic [5:0] ptr_disp_i,
    output logic [15:0] ptr_addr_o,
    // data space and io access
    input wire logic ds_wr_i,
    input wire logic [15:0] ds_addr_i,
    input wire logic [7:0] ds_wdata_i,
    output logic [7:0] ds_rdata_o,
    output logic ds_hit_o,
    input wire logic io_wr_i,
    input wire logic [5:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_hit_o,
    output logic [7:0] flags_o,
    output logic [15:0] sp_o
);
    logic [7:0] regs [core_state_pkg::NUM_REGS];
    logic [7:0] flags;
    logic [15:0] sp;
    logic [7:0] rd_a_lo;
    logic [7:0] rd_a_hi;
    logic [7:0] rd_b;
    logic [4:0] ptr_low_idx;
    logic [15:0] ptr_val;
    logic [15:0] ptr_next;
    logic [15:0] ptr_eff;
    logic ds_reg_hit;
    logic [4:0] ds_idx;
    logic [7:0] ds_rd;
    logic [7:0] io_rd;
    logic io_known;
    logic wr_sp_low;
    logic wr_sp_high;
    logic wr_flags;
    logic bit_value;
    logic [7:0] bit_target;
    logic [7:0] bit_loaded;

    // pointer pair lookup used by both address path and update
    function automatic logic [4:0] ptr_base(input logic [1:0] sel);
        case (sel)
            2'h0: ptr_base = core_state_pkg::PTR_FIRST_LOW; // RULE14
            2'h1: ptr_base = core_state_pkg::PTR_SECOND_LOW; // RULE14
            default: ptr_base = core_state_pkg::PTR_THIRD_LOW; // RULE14
        endcase
    endfunction : ptr_base

    // 16-bit read pairs even index with its odd neighbour
    assign rd_a_lo = regs[rd_wide_i ? {rd_a_idx_i[4:1], 1'b0} : rd_a_idx_i]; // RULE12
    assign rd_a_hi = rd_wide_i ? regs[{rd_a_idx_i[4:1], 1'b1}] : 8'h00; // RULE12
    assign rd_b = regs[rd_b_idx_i]; // RULE12 RULE22

    assign ptr_low_idx = ptr_base(ptr_sel_i);
    assign ptr_val = {regs[ptr_low_idx + 5'h01], regs[ptr_low_idx]}; // RULE14
    assign ptr_next = (ptr_mode_i == core_state_pkg::PTR_POST_INC) ? ptr_val + 16'h0001 : // RULE15
                      (ptr_mode_i == core_state_pkg::PTR_PRE_DEC) ? ptr_val - 16'h0001 : // RULE15
                      ptr_val;
    assign ptr_eff = (ptr_mode_i == core_state_pkg::PTR_DISP) ? ptr_val + {10'h000, ptr_disp_i} : // RULE15
                     (ptr_mode_i == core_state_pkg::PTR_PRE_DEC) ? ptr_next : ptr_val; // RULE15

    assign ds_reg_hit = ds_addr_i <= core_state_pkg::REGS_LAST_ADDR; // RULE13
    assign ds_idx = ds_addr_i[4:0]; // RULE13
    assign ds_rd = ds_reg_hit ? regs[ds_idx] : 8'h00;

    assign wr_sp_low = io_wr_i && io_addr_i == core_state_pkg::IO_SP_LOW; // RULE20
    assign wr_sp_high = io_wr_i && io_addr_i == core_state_pkg::IO_SP_HIGH; // RULE20
    assign wr_flags = io_wr_i && io_addr_i == core_state_pkg::IO_FLAGS;
    assign io_known = io_addr_i == core_state_pkg::IO_SP_LOW
                   || io_addr_i == core_state_pkg::IO_SP_HIGH
                   || io_addr_i == core_state_pkg::IO_FLAGS;
    assign io_rd = (io_addr_i == core_state_pkg::IO_SP_LOW) ? sp[7:0] :
                   (io_addr_i == core_state_pkg::IO_SP_HIGH) ? sp[15:8] :
                   (io_addr_i == core_state_pkg::IO_FLAGS) ? flags : 8'h00;

    assign bit_value = regs[bit_reg_i][bit_sel_i]; // RULE5
    assign bit_target = regs[bit_reg_i];
    always_comb begin
        bit_loaded = bit_target;
        bit_loaded[bit_sel_i] = flags[core_state_pkg::FLAG_BIT_STORE]; // RULE5
    end

    flags_unit u_flags (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .ie_op_i(ie_op_i),
        .irq_taken_i(irq_taken_i),
        .bit_store_op_i(bit_store_op_i),
        .bit_store_val_i(bit_value),
        .alu_flags_i(alu_flags_i),
        .alu_mask_i(alu_mask_i),
        .io_wr_i(wr_flags),
        .io_wdata_i(io_wdata_i),
        .flags_o(flags)
    );

    stack_pointer_unit #(
        .SP_WIDTH(SP_WIDTH),
        .RESET_VALUE(SRAM_LAST)
    ) u_sp (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .op_i(sp_op_i),
        .wr_low_i(wr_sp_low),
        .wr_high_i(wr_sp_high),
        .wdata_i(io_wdata_i),
        .sp_o(sp)
    );

    // register storage; later writes in this list win
    genvar gi;
    generate
        for (gi = 0; gi < core_state_pkg::NUM_REGS; gi++) begin : g_reg
            logic [7:0] next_reg;
            logic wide_lo;
            logic wide_hi;
            logic is_ptr_lo;
            logic is_ptr_hi;
            assign wide_lo = wr_wide_i && gi == {wr_idx_i[4:1], 1'b0};
            assign wide_hi = wr_wide_i && gi == {wr_idx_i[4:1], 1'b1};
            assign is_ptr_lo = ptr_en_i && gi == ptr_low_idx;
            assign is_ptr_hi = ptr_en_i && gi == ptr_low_idx + 5'h01;
            always_comb begin
                next_reg = regs[gi];
                if (is_ptr_lo && ptr_mode_i != core_state_pkg::PTR_DISP) begin
                    next_reg = ptr_next[7:0]; // RULE15
                end
                if (is_ptr_hi && ptr_mode_i != core_state_pkg::PTR_DISP) begin
                    next_reg = ptr_next[15:8]; // RULE15
                end
                if (ds_wr_i && ds_reg_hit && gi == ds_idx) begin
                    next_reg = ds_wdata_i; // RULE13
                end
                if (bit_load_op_i && gi == bit_reg_i) begin
                    next_reg = bit_loaded; // RULE5
                end
                if (wr_en_i && !wr_wide_i && gi == wr_idx_i) begin
                    next_reg = wr_data_i[7:0]; // RULE12 RULE22
                end
                if (wr_en_i && wide_lo) begin
                    next_reg = wr_data_i[7:0]; // RULE12
                end
                if (wr_en_i && wide_hi) begin
                    next_reg = wr_data_i[15:8]; // RULE12
                end
            end
            always_ff @(posedge clk_sys_i) begin
                if (sys_rst_i) begin
                    regs[gi] <= 8'h00;
                end else begin
                    regs[gi] <= next_reg;
                end
            end
        end
    endgenerate

    // registered outputs
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rd_a_data_o <= 16'h0000;
            rd_b_data_o <= 8'h00;
            ptr_addr_o <= 16'h0000;
            ds_rdata_o <= 8'h00;
            ds_hit_o <= 1'b0;
            io_rdata_o <= 8'h00;
            io_hit_o <= 1'b0;
            irq_accept_o <= 1'b0;
        end else begin
            rd_a_data_o <= {rd_a_hi, rd_a_lo};
            rd_b_data_o <= rd_b;
            ptr_addr_o <= ptr_eff;
            ds_rdata_o <= ds_rd;
            ds_hit_o <= ds_reg_hit;
            io_rdata_o <= io_rd;
            io_hit_o <= io_known;
            irq_accept_o <= irq_request_i && flags[core_state_pkg::FLAG_IRQ_EN]
                && ie_op_i != core_state_pkg::IE_CLEAR && !irq_taken_i; // RULE1 RULE2
        end
    end

    assign flags_o = flags;
    assign sp_o = sp;
endmodule : cpu_flags_regfile_stack
`default_nettype wire

//--- verification/alu_model.sv
// alu model: adds two bytes and gives the raw flag values
// assumes it sits combinationally beside the core state block
`timescale 1ns/10ps
`default_nettype none
module alu_model (
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    output logic [5:0] flags_o
);
    logic [8:0] sum;
    assign sum = {1'b0, a_i} + {1'b0, b_i};
    assign flags_o[5] = ({1'b0, a_i[3:0]} + {1'b0, b_i[3:0]}) > 5'h0F;
    assign flags_o[3] = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
    assign flags_o[2] = sum[7];
    assign flags_o[4] = flags_o[2] ^ flags_o[3];
    assign flags_o[1] = sum[7:0] == 8'h00;
    assign flags_o[0] = sum[8];
endmodule : alu_model
`default_nettype wire

//--- verification/cpu_state_checker_props.sv
// checker: cycle relations on the core state block ports
// assumes one clock and synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module cpu_state_checker #(
    parameter logic [15:0] SRAM_LAST = core_state_pkg::LAST_SRAM_ADDRESS
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [5:0] alu_flags_i,
    input wire logic [5:0] alu_mask_i,
    input wire logic irq_request_i,
    input wire logic irq_taken_i,
    input wire core_state_pkg::ie_op_t ie_op_i,
    input wire logic irq_accept_o,
    input wire core_state_pkg::sp_op_t sp_op_i,
    input wire logic io_wr_i,
    input wire logic [15:0] ds_addr_i,
    input wire logic ds_hit_o,
    input wire logic [7:0] flags_o,
    input wire logic [15:0] sp_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    property p_sign; flags_o[4] == (flags_o[2] ^ flags_o[3]); endproperty
    a_sign: assert property (p_sign) else $error("sign bit wrong");
    property p_irq_on; irq_request_i && flags_o[7] && ie_op_i == core_state_pkg::IE_KEEP
        && !irq_taken_i |=> irq_accept_o; endproperty
    a_irq_on: assert property (p_irq_on) else $error("request not accepted");
    property p_irq_off; !flags_o[7] |=> !irq_accept_o; endproperty
    a_irq_off: assert property (p_irq_off) else $error("accepted while disabled");
    property p_taken; irq_taken_i |=> !flags_o[7]; endproperty
    a_taken: assert property (p_taken) else $error("entry kept enable");
    property p_ie_set; ie_op_i == core_state_pkg::IE_SET && !irq_taken_i |=> flags_o[7]; endproperty
    a_ie_set: assert property (p_ie_set) else $error("enable not set");
    property p_ie_clr; ie_op_i == core_state_pkg::IE_CLEAR |=> !flags_o[7] && !irq_accept_o;
    endproperty
    a_ie_clr: assert property (p_ie_clr) else $error("clear not immediate");
    // io writes to the flags override the alu
    property p_alu; alu_mask_i != 6'h00 && !io_wr_i |=>
        ((flags_o[5:0] ^ $past(alu_flags_i)) & $past(alu_mask_i) & 6'h2F) == 6'h00; endproperty
    a_alu: assert property (p_alu) else $error("alu flag lost");
    property p_push2; sp_op_i == core_state_pkg::SP_PUSH2 && !io_wr_i
        |=> sp_o == $past(sp_o) - 16'h0002; endproperty
    a_push2: assert property (p_push2) else $error("call step wrong");
    property p_pop2; sp_op_i == core_state_pkg::SP_POP2 && !io_wr_i
        |=> sp_o == $past(sp_o) + 16'h0002; endproperty
    a_pop2: assert property (p_pop2) else $error("return step wrong");
    property p_push1; sp_op_i == core_state_pkg::SP_PUSH1 && !io_wr_i
        |=> sp_o == $past(sp_o) - 16'h0001; endproperty
    a_push1: assert property (p_push1) else $error("push step wrong");
    property p_reset; $fell(sys_rst_i)
        |-> sp_o == SRAM_LAST && flags_o == 8'h00; endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_ds_hit; 1'b1 |=> ds_hit_o == ($past(ds_addr_i) <= 16'h001F); endproperty
    a_ds_hit: assert property (p_ds_hit) else $error("data space hit wrong");
endmodule : cpu_state_checker
`default_nettype wire

//--- verification/tb.sv
// testbench: drives the core state block cycle by cycle and checks its ports
// assumes the alu model supplies raw flags from two operand bytes
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [15:0] SRAM_LAST = 16'h04FF;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [4:0] rd_a_idx_i, rd_b_idx_i, wr_idx_i, bit_reg_i;
    logic rd_wide_i, wr_en_i, wr_wide_i, bit_store_op_i, bit_load_op_i, irq_request_i;
    logic irq_taken_i, ptr_en_i, ds_wr_i, io_wr_i, irq_accept_o, ds_hit_o, io_hit_o;
    logic [15:0] wr_data_i, ds_addr_i, rd_a_data_o, ptr_addr_o, sp_o;
    logic [7:0] ds_wdata_i, io_wdata_i, rd_b_data_o, ds_rdata_o, io_rdata_o, flags_o, op_a, op_b;
    logic [5:0] alu_mask_i, ptr_disp_i, io_addr_i;
    wire logic [5:0] alu_flags_i;
    logic [2:0] bit_sel_i;
    logic [1:0] ptr_sel_i;
    core_state_pkg::ie_op_t ie_op_i;
    core_state_pkg::sp_op_t sp_op_i;
    core_state_pkg::ptr_mode_t ptr_mode_i;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    cpu_flags_regfile_stack #(.SP_WIDTH(12), .SRAM_LAST(SRAM_LAST)) i_dut (.*);
    alu_model i_alu (.a_i(op_a), .b_i(op_b), .flags_o(alu_flags_i));
    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 400) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic idle();
        {rd_a_idx_i, rd_b_idx_i, wr_idx_i, bit_reg_i, bit_sel_i, ptr_sel_i, rd_wide_i} = '0;
        {wr_en_i, wr_wide_i, bit_store_op_i, bit_load_op_i, irq_request_i, irq_taken_i} = '0;
        {ptr_en_i, ds_wr_i, io_wr_i, wr_data_i, ds_addr_i, ds_wdata_i, io_wdata_i} = '0;
        {op_a, op_b, alu_mask_i, ptr_disp_i, io_addr_i} = '0;
        ie_op_i = core_state_pkg::IE_KEEP;
        sp_op_i = core_state_pkg::SP_HOLD;
        ptr_mode_i = core_state_pkg::PTR_DISP;
    endtask : idle
    task automatic tick();
        @(posedge clk_sys_i);
        #2;
        idle();
    endtask : tick
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    task automatic t_regs();
        {wr_en_i, wr_idx_i, wr_data_i} = {1'b1, 5'h03, 16'h0055};
        tick();
        {wr_en_i, wr_wide_i, wr_idx_i, wr_data_i, rd_b_idx_i} = {2'b11, 5'h1A, 16'hBEEF, 5'h03};
        tick();
        check("byte read", rd_b_data_o, 16'h0055);
        {rd_wide_i, rd_a_idx_i, rd_b_idx_i, ds_addr_i} = {1'b1, 5'h1A, 5'h1B, 16'h001A};
        tick();
        check("pair read", rd_a_data_o, 16'hBEEF);
        check("pair high", rd_b_data_o, 16'h00BE);
        check("ds low byte", {ds_hit_o, ds_rdata_o}, 16'h01EF);
        {ds_wr_i, ds_addr_i, ds_wdata_i} = {1'b1, 16'h0020, 8'hA5};
        tick();
        check("ds unmapped", {ds_hit_o, ds_rdata_o}, 16'h0000);
        {ds_wr_i, ds_addr_i, ds_wdata_i} = {1'b1, 16'h0005, 8'h3C};
        tick();
        rd_b_idx_i = 5'h05;
        tick();
        check("ds write", rd_b_data_o, 16'h003C);
        check("ds write ignored", {ds_hit_o, ds_rdata_o}, 16'h0100);
        $display("register file test done");
    endtask : t_regs
    task automatic t_ptr();
        ptr_en_i = 1'b1;
        ptr_mode_i = core_state_pkg::PTR_POST_INC;
        tick();
        check("post increment", ptr_addr_o, 16'hBEEF);
        ptr_en_i = 1'b1;
        ptr_mode_i = core_state_pkg::PTR_PRE_DEC;
        tick();
        check("pre decrement", ptr_addr_o, 16'hBEEF);
        {ptr_en_i, ptr_disp_i} = {1'b1, 6'h3F};
        tick();
        check("displacement", ptr_addr_o, 16'hBF2E);
        {wr_en_i, wr_wide_i, wr_idx_i, wr_data_i} = {2'h3, 5'h1F, 16'h1234};
        tick();
        {ptr_en_i, ptr_sel_i} = {1'b1, 2'h2};
        ptr_mode_i = core_state_pkg::PTR_POST_INC;
        tick();
        check("third pointer", ptr_addr_o, 16'h1234);
        {rd_wide_i, rd_a_idx_i} = {1'b1, 5'h1E};
        tick();
        check("post increment write back", rd_a_data_o, 16'h1235);
        $display("pointer test done");
    endtask : t_ptr
    task automatic t_flags();
        {op_a, op_b, alu_mask_i} = {8'h7F, 8'h01, 6'h3F};
        tick();
        check("flags 7F+01", flags_o, 16'h002C);
        {op_a, op_b, alu_mask_i} = {8'hFF, 8'h01, 6'h3F};
        tick();
        check("flags FF+01", flags_o, 16'h0023);
        {bit_store_op_i, bit_reg_i, bit_sel_i} = {1'b1, 5'h03, 3'h2};
        tick();
        check("bit store", flags_o, 16'h0063);
        {bit_load_op_i, bit_reg_i, bit_sel_i} = {1'b1, 5'h04, 3'h7};
        tick();
        rd_b_idx_i = 5'h04;
        tick();
        check("bit load", rd_b_data_o, 16'h0080);
        $display("flag test done");
    endtask : t_flags
    task automatic t_irq();
        irq_request_i = 1'b1;
        ie_op_i = core_state_pkg::IE_SET;
        tick();
        check("enable set", flags_o[7], 1'b1);
        irq_request_i = 1'b1;
        tick();
        check("accepted", irq_accept_o, 1'b1);
        {irq_request_i, irq_taken_i} = 2'b11;
        tick();
        check("entry clears", flags_o[7], 1'b0);
        irq_request_i = 1'b1;
        tick();
        check("held off", irq_accept_o, 1'b0);
        ie_op_i = core_state_pkg::IE_SET;
        tick();
        check("return sets", flags_o[7], 1'b1);
        irq_request_i = 1'b1;
        ie_op_i = core_state_pkg::IE_CLEAR;
        tick();
        check("clear blocks", {flags_o[7], irq_accept_o}, 16'h0000);
        $display("interrupt test done");
    endtask : t_irq
    task automatic t_sp();
        logic [15:0] exp;
        exp = 16'h0340;
        {io_wr_i, io_addr_i, io_wdata_i} = {1'b1, 6'h3D, 8'h40};
        tick();
        {io_wr_i, io_addr_i, io_wdata_i} = {1'b1, 6'h3E, 8'h03};
        tick();
        check("sp io write", sp_o, exp);
        for (int i = 1; i <= 4; i++) begin
            sp_op_i = core_state_pkg::sp_op_t'(i);
            exp = (i % 2 == 1) ? exp - 16'((i + 1) / 2) : exp + 16'((i + 1) / 2);
            tick();
            check("sp step", sp_o, exp);
        end
        io_addr_i = 6'h3E;
        tick();
        check("sp high read", {io_hit_o, io_rdata_o}, 16'h0103);
        {io_wr_i, io_addr_i, io_wdata_i} = {1'b1, 6'h3F, 8'h84};
        tick();
        check("flags written", flags_o, 16'h0094);
        io_addr_i = 6'h10;
        tick();
        check("io unmapped", {io_hit_o, io_rdata_o}, 16'h0000);
        $display("stack pointer test done");
    endtask : t_sp
    initial begin
        idle();
        repeat (3) @(posedge clk_sys_i);
        #2;
        sys_rst_i = 1'b0;
        check("sp after reset", sp_o, SRAM_LAST);
        check("flags after reset", flags_o, 16'h0000);
        t_regs();
        t_ptr();
        t_flags();
        t_irq();
        t_sp();
        give_verdict();
    end
endmodule : tb
bind cpu_flags_regfile_stack cpu_state_checker #(.SRAM_LAST(SRAM_LAST)) i_chk (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .alu_flags_i(alu_flags_i),
    .alu_mask_i(alu_mask_i),
    .irq_request_i(irq_request_i),
    .irq_taken_i(irq_taken_i),
    .ie_op_i(ie_op_i),
    .irq_accept_o(irq_accept_o),
    .sp_op_i(sp_op_i),
    .io_wr_i(io_wr_i),
    .ds_addr_i(ds_addr_i),
    .ds_hit_o(ds_hit_o),
    .flags_o(flags_o),
    .sp_o(sp_o)
);
`default_nettype wire
